// ---- hdl/bcs_cmd_status.sv ----
`timescale 1ns/100ps
`include "bcs_params.svh"

// Operation
// R1 - Special cycle enable reads zero, read-only.
// R2 - Bit 4 gates write-invalidate in PCI mode.
// R3 - Bit 5 snoops palette writes in reverse.
// R4 - Parity response off: ignore, still flag bit31.
// R5 - Parity response on: flag and report errors.
// R6 - Stepping control bit reads zero, not preloaded.
// R7 - Error enable gates signaled system error bit.
// R8 - Forward mode: error messages to root complex.
// R9 - Reverse mode: errors assert system error pin.
// R10 - Fast back-to-back enable reads zero, read-only.
// R11 - Forward: interrupt messages only when enabled.
// R12 - Reverse: interrupt pin only when enabled.
// R13 - Interrupt status shows internal pending interrupt.
// R14 - Interrupt status ignores secondary interrupt inputs.
// R15 - Capabilities list bit always reads one.
// R16 - 66 MHz capable: 0 forward, 1 reverse.
// R17 - Back-to-back capable: 0 forward, 1 reverse.
// R18 - Master parity flag needs parity response enabled.
// R19 - Reserved bits read zero, ignore writes.
// R20 - Preloadable fields take EEPROM values after reset.

module bcs_cmd_status
    import bcs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire bcs_cfg_s    cfg_i,
    output logic             cfg_ack_o,
    output logic [31:0]      cfg_rdata_o,
    input  wire logic        reverse_mode_i,
    input  wire logic        pci_conv_mode_i,
    input  wire bcs_evt_s    evt_i,
    input  wire logic        int_pending_i,
    input  wire logic        ee_present_i,
    input  wire logic        ee_wr_i,
    input  wire logic [10:0] ee_data_i,
    input  wire logic        ee_done_i,
    output logic             mwi_en_o,
    output logic             pal_snoop_o,
    output logic             perr_report_o,
    output logic             err_msg_o,
    output logic             serr_o,
    output logic             serr_oe_n_o,
    output logic             inta_assert_msg_o,
    output logic             inta_deassert_msg_o,
    output logic             inta_o,
    output logic             inta_oe_n_o,
    output logic             cfg_ready_o
);

    // ==================================================================
    // Reset release
    logic rst_meta_n;
    logic rst_n;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // ==================================================================
    // Mode strap from a pin, filtered
    logic rev_mode;

    bcs_sync #(
        .WIDTH (1)
    ) u_mode_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .async_i (reverse_mode_i),
        .sync_o  (rev_mode)
    );

    // ==================================================================
    // Serial EEPROM preload
    logic        ee_load;
    logic [10:0] ee_load_data;
    logic        ee_busy;

    bcs_ee_load u_ee_load (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n),
        .ee_present_i (ee_present_i),
        .ee_wr_i      (ee_wr_i),
        .ee_data_i    (ee_data_i),
        .ee_done_i    (ee_done_i),
        .load_o       (ee_load),
        .load_data_o  (ee_load_data),
        .busy_o       (ee_busy)
    );

    // ==================================================================
    // Access decode
    logic cfg_hit;
    logic cfg_wr;
    logic cfg_rd;

    assign cfg_hit = cfg_i.req &&
                     (cfg_i.addr[7:2] == 6'(`BCS_CMD_STS_OFFSET >> 2)) &&
                     !ee_busy;
    assign cfg_wr  = cfg_hit && cfg_i.we;
    assign cfg_rd  = cfg_hit && !cfg_i.we;

    // ==================================================================
    // Command bits
    logic [10:0] cmd;
    logic [10:0] cmd_wmask;

    // Byte enables restrict which command bits a write may touch
    assign cmd_wmask = `BCS_CMD_RW_MASK &
                       {{3{cfg_i.be[1]}}, {8{cfg_i.be[0]}}};

    // Only RW bits are stored; 3, 7 and 9 stay zero
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= `BCS_CMD_RESET;
        end else if (ee_load) begin
            cmd <= ee_load_data & `BCS_CMD_RW_MASK; // see R20 see R6
        end else if (cfg_wr) begin
            cmd <= (cmd & ~cmd_wmask) |
                   (cfg_i.wdata[10:0] & cmd_wmask); // see R1 see R10
        end
    end

    logic perr_resp;
    logic serr_en;
    logic int_dis;

    assign perr_resp = cmd[`BCS_BIT_PERR_RESP];
    assign serr_en   = cmd[`BCS_BIT_SERR_EN];
    assign int_dis   = cmd[`BCS_BIT_INT_DIS];

    // ==================================================================
    // Sticky status flags; a set in the clearing cycle wins
    logic det_perr;
    logic mst_perr;
    logic sig_serr;
    logic sys_err;
    logic clr_det;
    logic clr_mst;
    logic clr_sig;

    assign sys_err = evt_i.fatal_err || evt_i.nonfatal_err;
    assign clr_det = cfg_wr && cfg_i.be[3] &&
                     cfg_i.wdata[`BCS_BIT_DET_PERR];
    assign clr_sig = cfg_wr && cfg_i.be[3] &&
                     cfg_i.wdata[`BCS_BIT_SIG_SERR];
    assign clr_mst = cfg_wr && cfg_i.be[3] &&
                     cfg_i.wdata[`BCS_BIT_MST_PERR];

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            det_perr <= 1'b0;
        end else if (evt_i.perr_det) begin
            det_perr <= 1'b1; // see R4
        end else if (clr_det) begin
            det_perr <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mst_perr <= 1'b0;
        end else if (evt_i.mst_perr && perr_resp) begin
            mst_perr <= 1'b1; // see R18 see R5
        end else if (clr_mst) begin
            mst_perr <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sig_serr <= 1'b0;
        end else if (sys_err && serr_en) begin
            sig_serr <= 1'b1; // see R7
        end else if (clr_sig) begin
            sig_serr <= 1'b0;
        end
    end

    // ==================================================================
    // Read data
    logic [31:0] rd_word;

    always_comb begin
        rd_word                     = 32'h0000_0000; // see R19
        rd_word[10:0]               = cmd;
        rd_word[`BCS_BIT_INT_STS]   = int_pending_i; // see R13 see R14
        rd_word[`BCS_BIT_CAP_LIST]  = `BCS_CAP_LIST_VAL; // see R15
        rd_word[`BCS_BIT_66MHZ]     = rev_mode; // see R16
        rd_word[`BCS_BIT_FBB_CAP]   = rev_mode; // see R17
        rd_word[`BCS_BIT_MST_PERR]  = mst_perr;
        rd_word[`BCS_BIT_SIG_SERR]  = sig_serr;
        rd_word[`BCS_BIT_DET_PERR]  = det_perr;
    end

    // Unmapped offsets answer with zero; while preload is busy no access is answered
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ack_o   <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
        end else begin
            cfg_ack_o   <= cfg_i.req && !ee_busy;
            cfg_rdata_o <= cfg_rd ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ready_o <= 1'b0;
        end else begin
            cfg_ready_o <= !ee_busy;
        end
    end

    // ==================================================================
    // Datapath steering
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mwi_en_o    <= 1'b0;
            pal_snoop_o <= 1'b0;
        end else begin
            mwi_en_o    <= pci_conv_mode_i &&
                           cmd[`BCS_BIT_MWI_EN]; // see R2
            // Palette snooping exists only behind a reverse bridge
            pal_snoop_o <= rev_mode &&
                           cmd[`BCS_BIT_PAL_SNOOP]; // see R3
        end
    end

    // ==================================================================
    // Error reporting
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            perr_report_o <= 1'b0;
            err_msg_o     <= 1'b0;
            serr_o        <= 1'b1;
            serr_oe_n_o   <= 1'b1;
        end else begin
            perr_report_o <= (evt_i.perr_det || evt_i.mst_perr) &&
                             perr_resp; // see R4 see R5
            err_msg_o     <= !rev_mode && sys_err && serr_en; // see R8
            // Open drain: only ever drives low, for one cycle
            serr_oe_n_o   <= !(rev_mode && sys_err && serr_en); // see R9
            serr_o        <= 1'b0;
        end
    end

    // ==================================================================
    // Interrupt delivery
    logic int_want;
    logic msg_state;

    assign int_want = int_pending_i && !int_dis;

    // Messages follow edges of the gated level, so setting the
    // disable bit while asserted sends a deassert message
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            msg_state           <= 1'b0;
            inta_assert_msg_o   <= 1'b0;
            inta_deassert_msg_o <= 1'b0;
        end else begin
            inta_assert_msg_o   <= 1'b0;
            inta_deassert_msg_o <= 1'b0;
            if (!rev_mode && int_want && !msg_state) begin
                msg_state         <= 1'b1;
                inta_assert_msg_o <= 1'b1; // see R11
            end else if (msg_state && (!int_want || rev_mode)) begin
                msg_state           <= 1'b0;
                inta_deassert_msg_o <= 1'b1; // see R11
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            inta_o      <= 1'b1;
            inta_oe_n_o <= 1'b1;
        end else begin
            inta_o      <= 1'b0;
            inta_oe_n_o <= !(rev_mode && int_want); // see R12
        end
    end

    // ==================================================================
    // Checks
    chk_spec_cyc_zero: assert property ( // see R1
        @(posedge clk_i) disable iff (!rst_n)
        cfg_ack_o |-> !cfg_rdata_o[`BCS_BIT_SPEC_CYC])
        else $error("special cycle enable read nonzero");

    chk_step_fbb_zero: assert property ( // see R6
        @(posedge clk_i) disable iff (!rst_n)
        !cmd[`BCS_BIT_STEP_CTRL] && !cmd[`BCS_BIT_FBB_EN])
        else $error("read-only command bit became set");

    chk_mwi_gate: assert property ( // see R2
        @(posedge clk_i) disable iff (!rst_n)
        ##1 mwi_en_o == $past(pci_conv_mode_i && cmd[`BCS_BIT_MWI_EN]))
        else $error("write-invalidate enable wrong");

    chk_sig_serr_gate: assert property ( // see R7
        @(posedge clk_i) disable iff (!rst_n)
        $rose(sig_serr) |-> $past(serr_en && sys_err))
        else $error("system error flag set while disabled");

    chk_mst_perr_gate: assert property ( // see R18
        @(posedge clk_i) disable iff (!rst_n)
        (evt_i.mst_perr && !perr_resp && !mst_perr) |=> !mst_perr)
        else $error("master parity flag set while disabled");

    chk_det_perr_set: assert property ( // see R4
        @(posedge clk_i) disable iff (!rst_n)
        evt_i.perr_det |=> det_perr)
        else $error("detected parity flag not set");

    chk_serr_pin: assert property ( // see R9
        @(posedge clk_i) disable iff (!rst_n)
        (rev_mode && sys_err && serr_en) ##1 rev_mode |->
        !serr_oe_n_o && !serr_o)
        else $error("system error pin not driven");

    chk_err_msg: assert property ( // see R8
        @(posedge clk_i) disable iff (!rst_n)
        err_msg_o |-> $past(!rev_mode && serr_en && sys_err))
        else $error("error message without cause");

    chk_inta_pin: assert property ( // see R12
        @(posedge clk_i) disable iff (!rst_n)
        !inta_oe_n_o |-> $past(int_want && rev_mode))
        else $error("interrupt pin driven while disabled");

    chk_inta_msg: assert property ( // see R11
        @(posedge clk_i) disable iff (!rst_n)
        inta_assert_msg_o |-> $past(int_want) && !$past(rev_mode))
        else $error("interrupt message while disabled");

    chk_cap_mode: assert property ( // see R15
        @(posedge clk_i) disable iff (!rst_n)
        (cfg_rd && !$changed(rev_mode)) |=>
        cfg_rdata_o[`BCS_BIT_CAP_LIST] &&
        (cfg_rdata_o[`BCS_BIT_66MHZ] == $past(rev_mode)) &&
        (cfg_rdata_o[`BCS_BIT_FBB_CAP] == $past(rev_mode)))
        else $error("capability bits wrong");

    chk_reserved_zero: assert property ( // see R19
        @(posedge clk_i) disable iff (!rst_n)
        cfg_ack_o |-> (cfg_rdata_o[18:11] == 8'h00) &&
        !cfg_rdata_o[22] && (cfg_rdata_o[29:25] == 5'h00))
        else $error("reserved bits read nonzero");

endmodule : bcs_cmd_status

// ---- hdl/bcs_params.svh ----
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH

// ======================================================================
// Register location
`define BCS_CMD_STS_OFFSET   8'h04

// ======================================================================
// Command field positions
`define BCS_BIT_SPEC_CYC     3
`define BCS_BIT_MWI_EN       4
`define BCS_BIT_PAL_SNOOP    5
`define BCS_BIT_PERR_RESP    6
`define BCS_BIT_STEP_CTRL    7
`define BCS_BIT_SERR_EN      8
`define BCS_BIT_FBB_EN       9
`define BCS_BIT_INT_DIS      10

// ======================================================================
// Status field positions
`define BCS_BIT_INT_STS      19
`define BCS_BIT_CAP_LIST     20
`define BCS_BIT_66MHZ        21
`define BCS_BIT_FBB_CAP      23
`define BCS_BIT_MST_PERR     24
`define BCS_BIT_SIG_SERR     30
`define BCS_BIT_DET_PERR     31

// ======================================================================
// Reset values and masks
`define BCS_CMD_RESET        11'h000
`define BCS_CMD_RW_MASK      11'h570
`define BCS_CAP_LIST_VAL     1'h1

`endif

// ---- hdl/bcs_pkg.sv ----
package bcs_pkg;

    // ==================================================================
    // Configuration access carrier
    typedef struct packed {
        logic        req;
        logic        we;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } bcs_cfg_s;

    // ==================================================================
    // Error and parity events from the datapath, one-cycle pulses
    typedef struct packed {
        logic perr_det;
        logic mst_perr;
        logic fatal_err;
        logic nonfatal_err;
    } bcs_evt_s;

    // ==================================================================
    // Preload sequencer states
    typedef enum logic [2:0] {
        BCS_EE_IDLE = 3'b001,
        BCS_EE_LOAD = 3'b010,
        BCS_EE_DONE = 3'b100
    } bcs_ee_state_e;

endpackage : bcs_pkg

// ---- hdl/bcs_sync.sv ----
`timescale 1ns/100ps

module bcs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ==================================================================
    // Three stages; value moves only when the last two agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_o <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    sync_o[i] <= stage3[i];
                end
            end
        end
    end

endmodule : bcs_sync

// ---- hdl/bcs_ee_load.sv ----
`timescale 1ns/100ps

module bcs_ee_load
    import bcs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ee_present_i,
    input  wire logic        ee_wr_i,
    input  wire logic [10:0] ee_data_i,
    input  wire logic        ee_done_i,
    output logic             load_o,
    output logic [10:0]      load_data_o,
    output logic             busy_o
);

    bcs_ee_state_e state;

    // ==================================================================
    // Sequencer: waits for the image when a device is present
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= BCS_EE_IDLE;
        end else begin
            unique case (state)
                BCS_EE_IDLE: begin
                    state <= ee_present_i ? BCS_EE_LOAD : BCS_EE_DONE;
                end
                BCS_EE_LOAD: begin
                    if (ee_done_i || !ee_present_i) begin
                        state <= BCS_EE_DONE;
                    end
                end
                BCS_EE_DONE: begin
                    state <= BCS_EE_DONE;
                end
                default: begin
                    state <= BCS_EE_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_o      <= 1'b0;
            load_data_o <= '0;
        end else begin
            load_o <= (state == BCS_EE_LOAD) && ee_wr_i;
            if ((state == BCS_EE_LOAD) && ee_wr_i) begin
                load_data_o <= ee_data_i;
            end
        end
    end

    assign busy_o = (state != BCS_EE_DONE);

endmodule : bcs_ee_load

// ---- dv/bcs_cfg_host.sv ----
`timescale 1ns/100ps

module bcs_cfg_host
    import bcs_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] rdata_i,
    output bcs_cfg_s         cfg_o
);

    // ==========
    // Configuration access, moved only on falling edges
    initial cfg_o = '0;

    task automatic acc(input logic we, input logic [7:0] addr,
                       input logic [3:0] be, input logic [31:0] wd,
                       output logic [31:0] rd, output logic ok);
        ok = 1'b0;
        rd = 32'h0;
        @(negedge clk_i);
        cfg_o = {1'b1, we, addr, be, wd};
        @(negedge clk_i);
        // Released fields carry garbage so stale values cannot pass
        cfg_o = {1'b0, ~we, ~addr, ~be, ~wd};
        for (int n = 0; n < 4; n++) begin
            if (!ok && ack_i === 1'b1) begin
                ok = 1'b1;
                rd = rdata_i;
            end
            if (!ok) @(negedge clk_i);
        end
    endtask : acc

endmodule : bcs_cfg_host

// ---- dv/tb.sv ----
`timescale 1ns/100ps

module tb
    import bcs_pkg::*;
;
    logic        clk_i;
    logic        nrst_i;
    bcs_cfg_s    cfg;
    logic        ack;
    logic [31:0] rdata;
    logic        rev;
    logic        conv;
    bcs_evt_s    evt;
    logic        intp;
    logic        ee_pres;
    logic        ee_wr;
    logic [10:0] ee_data;
    logic        ee_done;
    logic        mwi, pal, rep, msg, serr, serr_oe_n;
    logic        ia, id, inta, inta_oe_n, ready;
    int          err_total, checks_done, cmd, sts, seed;
    int          n_rep, n_msg, n_serr, n_ia, n_id;

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    bcs_cmd_status u_bcs_cmd_status (
        .clk_i               (clk_i),
        .nrst_i              (nrst_i),
        .cfg_i               (cfg),
        .cfg_ack_o           (ack),
        .cfg_rdata_o         (rdata),
        .reverse_mode_i      (rev),
        .pci_conv_mode_i     (conv),
        .evt_i               (evt),
        .int_pending_i       (intp),
        .ee_present_i        (ee_pres),
        .ee_wr_i             (ee_wr),
        .ee_data_i           (ee_data),
        .ee_done_i           (ee_done),
        .mwi_en_o            (mwi),
        .pal_snoop_o         (pal),
        .perr_report_o       (rep),
        .err_msg_o           (msg),
        .serr_o              (serr),
        .serr_oe_n_o         (serr_oe_n),
        .inta_assert_msg_o   (ia),
        .inta_deassert_msg_o (id),
        .inta_o              (inta),
        .inta_oe_n_o         (inta_oe_n),
        .cfg_ready_o         (ready)
    );

    bcs_cfg_host u_bcs_cfg_host (
        .clk_i   (clk_i),
        .ack_i   (ack),
        .rdata_i (rdata),
        .cfg_o   (cfg)
    );

    // ==========
    // Checking and model
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t %s: seen %h exp %h", $time, what, seen, exp);
        end
    endtask : chk

    function automatic logic [31:0] exp_word();
        return 32'(cmd & 32'h570) | 32'(intp) << 19 | 32'h0010_0000
             | 32'(rev) << 21 | 32'(rev) << 23 | 32'(sts);
    endfunction : exp_word

    task automatic rd_chk(input string what);
        logic [31:0] d;
        logic        ok;
        u_bcs_cfg_host.acc(1'b0, 8'h04, 4'hf, 32'h0, d, ok);
        chk({31'h0, ok}, 32'h1, what);
        if (ok !== 1'b1) test_done();
        chk(d, exp_word(), what);
    endtask : rd_chk

    task automatic wr(input logic [31:0] d, input logic [3:0] be);
        logic [31:0] r;
        logic        ok;
        u_bcs_cfg_host.acc(1'b1, 8'h04, be, d, r, ok);
        if (be[0]) cmd = (cmd & 32'h700) | int'(d[7:0]);
        if (be[1]) cmd = (cmd & 32'h0ff) | int'({d[10:8], 8'h00});
        if (be[3]) sts = sts & ~int'(d & 32'hc100_0000);
        cmd = cmd & 32'h570;
        chk({31'h0, ok}, 32'h1, "write answer");
        if (ok !== 1'b1) test_done();
        chk(r, 32'h0, "write data");
    endtask : wr

    // Counts pulses over n cycles; also ends any one-cycle event
    task automatic watch(input int n);
        n_rep = 0; n_msg = 0; n_serr = 0; n_ia = 0; n_id = 0;
        repeat (n) begin
            @(negedge clk_i);
            evt = '0;
            n_rep += int'(rep === 1'b1);
            n_msg += int'(msg === 1'b1);
            n_serr += int'(serr_oe_n === 1'b0);
            n_ia += int'(ia === 1'b1);
            n_id += int'(id === 1'b1);
        end
    endtask : watch

    // k: 0 parity detect, 1 master parity, 2 fatal, 3 non-fatal
    task automatic fire(input int k);
        logic en_p;
        logic en_s;
        en_p = cmd[6];
        en_s = cmd[8];
        @(negedge clk_i);
        evt = bcs_evt_s'(4'h8 >> k);
        watch(4);
        if (k == 0) sts |= 32'h8000_0000;
        if (k == 1 && en_p) sts |= 32'h0100_0000;
        if (k > 1 && en_s) sts |= 32'h4000_0000;
        chk(n_rep, 32'(k < 2 && en_p), "parity report");
        chk(n_msg, 32'(k > 1 && en_s && !rev), "error msg");
        chk(n_serr, 32'(k > 1 && en_s && rev), "error pin");
    endtask : fire

    task automatic do_reset(input logic pres, input logic [10:0] img);
        int n;
        @(negedge clk_i);
        nrst_i = 1'b0;
        ee_pres = pres;
        repeat (4) @(negedge clk_i);
        nrst_i = 1'b1;
        cmd = pres ? int'(img) & 32'h570 : 0;
        sts = 0;
        if (pres) begin
            repeat (6) @(negedge clk_i);
            ee_data = img;
            ee_wr = 1'b1;
            @(negedge clk_i);
            ee_wr = 1'b0;
            ee_done = 1'b1;
            @(negedge clk_i);
            ee_done = 1'b0;
        end
        for (n = 0; n < 50 && ready !== 1'b1; n++) @(negedge clk_i);
        if (ready !== 1'b1) begin
            err_total++;
            test_done();
        end
        chk({30'h0, serr, inta}, 32'h0, "idle pins");
    endtask : do_reset

    task automatic set_rev(input logic v);
        rev = v;
        // Strap filter needs a few cycles to follow
        repeat (8) @(negedge clk_i);
    endtask : set_rev

    // ==========
    // Main sequence
    initial begin
        logic [31:0] d;
        logic        ok;
        seed = 32'h9bce;
        err_total = 0; checks_done = 0; cmd = 0; sts = 0;
        nrst_i = 1'b0; rev = 1'b0; conv = 1'b0; evt = '0;
        intp = 1'b0; ee_pres = 1'b0; ee_wr = 1'b0;
        ee_data = 11'h000; ee_done = 1'b0;
        // Image sets command bits 3 to 10; only writable ones may stick
        do_reset(1'b1, 11'h7f8);
        rd_chk("preload");
        wr(32'hffff_ffff, 4'b0111);
        rd_chk("fixed bits");
        for (int r = 0; r < 2; r++) begin
            set_rev(r[0]);
            rd_chk("mode bits");
            for (int i = 0; i < 6; i++) begin
                d = $random(seed);
                conv = d[31];
                wr(d, 4'b0011);
                repeat (3) @(negedge clk_i);
                chk({31'h0, mwi}, 32'(conv & cmd[4]), "mwi");
                chk({31'h0, pal}, 32'(rev & cmd[5]), "snoop");
                rd_chk("random write");
            end
            for (int i = 0; i < 16; i++) begin
                wr(32'(i[0]) << 6 | 32'(i[1]) << 8, 4'b0011);
                fire(i / 4);
                rd_chk("flags");
                wr(32'hc100_0000, 4'b1000);
            end
            rd_chk("flags cleared");
            for (int i = 0; i < 2; i++) begin
                wr(32'(i) << 10, 4'b0010);
                intp = 1'b1;
                watch(4);
                chk(n_ia, 32'(r == 0 && i == 0), "int msg");
                chk({31'h0, inta_oe_n}, 32'(r == 0 || i == 1),
                    "int pin");
                rd_chk("int pending");
                intp = 1'b0;
                watch(4);
                chk(n_id, 32'(r == 0 && i == 0), "int end");
                chk({31'h0, inta_oe_n}, 32'h1, "pin idle");
            end
        end
        u_bcs_cfg_host.acc(1'b0, 8'h08, 4'hf, 32'h0, d, ok);
        chk({31'h0, ok}, 32'h1, "unmapped ack");
        if (ok !== 1'b1) test_done();
        chk(d, 32'h0, "unmapped");
        set_rev(1'b0);
        do_reset(1'b0, 11'h7ff);
        rd_chk("defaults");
        test_done();
    end

endmodule : tb
